// ==== hdl/host_serial_port.sv ====
// Mode 1 serial slave that turns host frames into register strobes.
// Assumes the host clock is far slower than clk_sys (at least 8x).
`timescale 1ns/10ps
`default_nettype none

module host_serial_port (
    // System
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Host pins
    input  wire logic host_port_clock,
    input  wire logic host_port_select_n,
    input  wire logic host_port_mosi,
    output var  logic host_port_miso,
    output var  logic host_port_miso_oe,
    // Register side
    reg_access_if.port bus
);
    // Bit 0 clock, bit 1 select_n, bit 2 data in
    logic [2:0] s1_q, s2_q, s3_q, f_q;
    logic [4:0] cnt_q;
    logic       dir_q, pkt_done_q, rd_stb_q, wr_stb_q;
    logic [2:0] pkt_q;
    logic [9:0] addr_q;
    logic [7:0] data_q, wdata_q, tx_q;

    // Level accepted only once second and third stage agree
    wire [2:0] agree    = ~(s2_q ^ s3_q);
    wire [2:0] f_d      = (agree & s3_q) | (~agree & f_q);
    wire       clk_rise = f_d[0] & ~f_q[0];
    wire       clk_fall = ~f_d[0] & f_q[0];
    wire       sel      = ~f_d[1];
    wire       din      = f_d[2];
    wire       at_last  = cnt_q == pmic_irq_pkg::BIT_DATA_LAST;
    wire       in_addr  = cnt_q >= pmic_irq_pkg::BIT_ADDR_FIRST &&
                          cnt_q <= pmic_irq_pkg::BIT_ADDR_LAST;
    wire       in_data  = cnt_q >= pmic_irq_pkg::BIT_DATA_FIRST;
    wire       commit   = clk_fall && at_last && dir_q && !pkt_done_q;
    wire [4:0] cnt_nx   = !at_last ? cnt_q + 5'h01 :
                          dir_q ? pmic_irq_pkg::BIT_DIR :
                                  pmic_irq_pkg::BIT_DATA_FIRST;

    assign bus.rd_stb = rd_stb_q;
    assign bus.wr_stb = wr_stb_q;
    assign bus.addr   = addr_q;
    assign bus.wdata  = wdata_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_q <= 3'h2;
            s2_q <= 3'h2;
            s3_q <= 3'h2;
            f_q  <= 3'h2;
        end else begin
            s1_q <= {host_port_mosi, host_port_select_n, host_port_clock};
            s2_q <= s1_q;
            s3_q <= s2_q;
            f_q  <= f_d;
        end
    end

    // Deselect resets the slot counter, so every selection is fresh
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sel) begin
            cnt_q      <= pmic_irq_pkg::BIT_DIR;
            pkt_q      <= 3'h0;
            pkt_done_q <= 1'b0;
        end else if (clk_fall) begin
            cnt_q <= cnt_nx;
            if (commit && pkt_q == pmic_irq_pkg::LAST_PACKET) begin
                pkt_done_q <= 1'b1;
            end else if (commit) begin
                pkt_q <= pkt_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dir_q    <= 1'b0;
            addr_q   <= 10'h000;
            data_q   <= 8'h00;
            wdata_q  <= 8'h00;
            rd_stb_q <= 1'b0;
            wr_stb_q <= 1'b0;
        end else begin
            rd_stb_q <= sel && clk_fall && !dir_q &&
                        (cnt_q == pmic_irq_pkg::BIT_SPARE_LAST || at_last);
            wr_stb_q <= sel && commit;
            if (sel && clk_fall) begin
                if (cnt_q == pmic_irq_pkg::BIT_DIR) begin
                    dir_q <= din;
                end
                if (in_addr) begin
                    addr_q <= {addr_q[8:0], din};
                end
                if (at_last && !dir_q) begin
                    addr_q <= addr_q + 10'h001;
                end
                // Read frames never look at data-in past the address
                if (in_data && dir_q) begin
                    data_q <= {data_q[6:0], din};
                end
                if (commit) begin
                    wdata_q <= {data_q[6:0], din};
                end
            end
        end
    end

    // Host samples on falling edges, so data moves on rising edges
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sel) begin
            tx_q              <= 8'h00;
            host_port_miso    <= 1'b0;
            host_port_miso_oe <= 1'b0;
        end else begin
            host_port_miso_oe <= 1'b1;
            if (bus.rd_stb) begin
                tx_q <= bus.rdata;
            end else if (clk_rise && in_data && !dir_q) begin
                host_port_miso <= tx_q[7];
                tx_q           <= {tx_q[6:0], 1'b0};
            end else if (clk_rise) begin
                host_port_miso <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_released;
        f_q[1] && agree[1] && s3_q[1] |=> !host_port_miso_oe && !host_port_miso;
    endproperty
    a_released: assert property (p_released)
        else $error("data out driven while deselected");

    property p_commit;
        sel && commit |=> wr_stb_q ##1 !wr_stb_q;
    endproperty
    a_commit: assert property (p_commit)
        else $error("write not committed on 24th falling edge");

    property p_zero_slots;
        sel && clk_rise && !in_data |=> !host_port_miso;
    endproperty
    a_zero_slots: assert property (p_zero_slots)
        else $error("address or spare slot not zero on read");

    property p_increment;
        sel && clk_fall && at_last && !dir_q |=>
            addr_q == $past(addr_q) + 10'h001 && rd_stb_q;
    endproperty
    a_increment: assert property (p_increment)
        else $error("read address did not advance");

endmodule : host_serial_port

`default_nettype wire

// ==== hdl/pmic_irq_pkg.sv ====
// Constants shared by the interrupt controller and its host serial port.
// Assumes one 20 MHz system clock; every host pin is asynchronous to it.

package pmic_irq_pkg;

    // Frame slots, counted from zero at the first clock of a frame
    localparam logic [4:0] BIT_DIR        = 5'h00;
    localparam logic [4:0] BIT_ADDR_FIRST = 5'h01;
    localparam logic [4:0] BIT_ADDR_LAST  = 5'h0A;
    localparam logic [4:0] BIT_SPARE_LAST = 5'h0F;
    localparam logic [4:0] BIT_DATA_FIRST = 5'h10;
    localparam logic [4:0] BIT_DATA_LAST  = 5'h17;
    localparam logic [2:0] LAST_PACKET    = 3'h7;

    // Summary level
    localparam logic [9:0] ADDR_SUMMARY      = 10'h004;
    localparam logic [9:0] ADDR_SUMMARY_MASK = 10'h005;
    localparam logic [7:0] SUMMARY_VALID     = 8'h7F;
    localparam logic [7:0] SUMMARY_RST       = 8'h00;
    localparam logic [7:0] SUMMARY_MASK_RST  = 8'hFA;

    // Groups: 0 converter, 1 charger, 2 clock alarm, 3 general pin,
    // 4 regulator fault, 5 audio detect; group g drives summary bit g+1
    localparam int         GRP_N = 6;
    localparam logic [9:0] GRP_STAT_ADDR [GRP_N] =
        '{10'h05F, 10'h0D0, 10'h01C, 10'h0E8, 10'h030, 10'h197};
    localparam logic [9:0] GRP_MASK_ADDR [GRP_N] =
        '{10'h060, 10'h0D1, 10'h000, 10'h000, 10'h031, 10'h198};
    localparam logic [5:0] GRP_HAS_MASK = 6'h33;
    localparam logic [7:0] GRP_VALID [GRP_N] =
        '{8'h07, 8'hFE, 8'hB0, 8'hFF, 8'h07, 8'h0F};
    localparam logic [7:0] GRP_STAT_RST = 8'h00;
    localparam logic [7:0] GRP_MASK_RST [GRP_N] =
        '{8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h0F};

endpackage : pmic_irq_pkg

// ==== hdl/pmic_irq_top.sv ====
// Two-level interrupt controller with its host serial register port.
// Assumes event inputs are synchronous to clk_sys and active high.
`timescale 1ns/10ps
`default_nettype none

module pmic_irq_top (
    // System
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // Host serial port
    input  wire logic       host_port_clock,
    input  wire logic       host_port_select_n,
    input  wire logic       host_port_mosi,
    output var  logic       host_port_miso,
    output var  logic       host_port_miso_oe,
    // Host interrupt
    output var  logic       host_irq_out,
    // Event sources, held high or pulsed for one cycle
    input  wire logic       power_key_event,
    input  wire logic [7:0] converter_events,
    input  wire logic [7:0] charger_events,
    input  wire logic [7:0] clock_alarm_events,
    input  wire logic [7:0] general_pin_events,
    input  wire logic [7:0] regulator_fault_events,
    input  wire logic [7:0] audio_detect_events
);
    localparam int GN = pmic_irq_pkg::GRP_N;

    reg_access_if bus ();

    logic [7:0]    ev       [GN];
    logic [7:0]    stat_q   [GN];
    logic [7:0]    stat_d   [GN];
    logic [7:0]    mask2_q  [GN];
    logic [7:0]    grp_clr  [GN];
    logic [GN-1:0] stat_hit, mask_hit, grp_or, grp_prev_q, grp_rise;
    logic [GN-1:0] clr_grp_q;
    logic [7:0]    sum_q, sum_d, sum_set, sum_clr, mask1_q;
    logic [7:0]    clr_val_q, rd_grp;
    logic          clr_stb_q, clr_sum_q, irq_q;

    host_serial_port u_port (
        .clk_sys            (clk_sys),
        .sys_rst            (sys_rst),
        .host_port_clock    (host_port_clock),
        .host_port_select_n (host_port_select_n),
        .host_port_mosi     (host_port_mosi),
        .host_port_miso     (host_port_miso),
        .host_port_miso_oe  (host_port_miso_oe),
        .bus                (bus)
    );

    assign ev[0] = converter_events;
    assign ev[1] = charger_events;
    assign ev[2] = clock_alarm_events;
    assign ev[3] = general_pin_events;
    assign ev[4] = regulator_fault_events;
    assign ev[5] = audio_detect_events;

    wire sum_hit  = bus.addr == pmic_irq_pkg::ADDR_SUMMARY;
    wire summ_hit = bus.addr == pmic_irq_pkg::ADDR_SUMMARY_MASK;

    for (genvar g = 0; g < GN; g++) begin : grp
        assign stat_hit[g] = bus.addr == pmic_irq_pkg::GRP_STAT_ADDR[g];
        assign mask_hit[g] = pmic_irq_pkg::GRP_HAS_MASK[g] &&
                             bus.addr == pmic_irq_pkg::GRP_MASK_ADDR[g];
        // Only bits captured by the read are cleared
        assign grp_clr[g]  = (clr_stb_q && clr_grp_q[g]) ? clr_val_q
                                                         : 8'h00;
        // Set term is ORed after the clear, so a same-cycle event survives
        assign stat_d[g]   = ((stat_q[g] & ~grp_clr[g]) | ev[g]) &
                             pmic_irq_pkg::GRP_VALID[g];
        // Second-level mask gates the group output, never the status bit
        assign grp_or[g]   = |(stat_q[g] & ~mask2_q[g]);

        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                stat_q[g] <= pmic_irq_pkg::GRP_STAT_RST;
            end else begin
                stat_q[g] <= stat_d[g];
            end
        end

        // Groups without a mask register keep an all-clear mask
        always_ff @(posedge clk_sys) begin
            if (sys_rst) begin
                mask2_q[g] <= pmic_irq_pkg::GRP_MASK_RST[g];
            end else if (bus.wr_stb && mask_hit[g]) begin
                mask2_q[g] <= bus.wdata &
                              pmic_irq_pkg::GRP_VALID[g];
            end
        end
    end

    // A still-high group output hides later rises; the group read shows all
    assign grp_rise = grp_or & ~grp_prev_q;
    assign sum_set  = {1'b0, grp_rise, power_key_event};
    assign sum_clr  = (clr_stb_q && clr_sum_q) ? clr_val_q : 8'h00;
    assign sum_d    = ((sum_q & ~sum_clr) | sum_set) &
                      pmic_irq_pkg::SUMMARY_VALID;

    always_comb begin
        rd_grp = 8'h00;
        for (int g = 0; g < GN; g++) begin
            rd_grp = rd_grp | (stat_hit[g] ? stat_q[g] : 8'h00) |
                     (mask_hit[g] ? mask2_q[g] : 8'h00);
        end
    end

    // Unmapped addresses read as zero
    assign bus.rdata = sum_hit  ? sum_q :
                       summ_hit ? mask1_q : rd_grp;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sum_q      <= pmic_irq_pkg::SUMMARY_RST;
            grp_prev_q <= '0;
        end else begin
            sum_q      <= sum_d;
            grp_prev_q <= grp_or;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mask1_q <= pmic_irq_pkg::SUMMARY_MASK_RST;
        end else if (bus.wr_stb && summ_hit) begin
            mask1_q <= bus.wdata & pmic_irq_pkg::SUMMARY_VALID;
        end
    end

    // Self-clear one cycle after the read strobe, with the value sent
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clr_stb_q <= 1'b0;
            clr_sum_q <= 1'b0;
            clr_grp_q <= '0;
            clr_val_q <= 8'h00;
        end else begin
            clr_stb_q <= bus.rd_stb;
            clr_sum_q <= sum_hit;
            clr_grp_q <= stat_hit;
            clr_val_q <= bus.rdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sum_q & ~mask1_q);
        end
    end

    assign host_irq_out = irq_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_irq_high;
        |(sum_q & ~mask1_q) |=> host_irq_out;
    endproperty
    a_irq_high: assert property (p_irq_high)
        else $error("interrupt low with unmasked summary bit");

    property p_irq_low;
        (sum_q & ~mask1_q) == 8'h00 |=> !host_irq_out;
    endproperty
    a_irq_low: assert property (p_irq_low)
        else $error("interrupt high with nothing unmasked pending");

    property p_hold;
        sum_q[0] && !(clr_stb_q && clr_sum_q) |=> sum_q[0];
    endproperty
    a_hold: assert property (p_hold)
        else $error("summary bit dropped without a read");

    property p_set_wins;
        clr_stb_q && clr_sum_q && power_key_event |=> sum_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during clear");

    sequence s_sum_read;
        bus.rd_stb && sum_hit && bus.rdata[0];
    endsequence

    property p_read_clears;
        s_sum_read ##1 !power_key_event |=> !sum_q[0];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("captured summary bit not cleared");

    // Every converter group bit set before the summary read is still set after it
    property p_keep_groups;
        bus.rd_stb && sum_hit |=> ##1
            ($past(stat_q[0], 2) & ~stat_q[0]) == 8'h00;
    endproperty
    a_keep_groups: assert property (p_keep_groups)
        else $error("summary read disturbed group bits");

    sequence s_grp_rise;
        grp_rise[0] && !mask1_q[1];
    endsequence

    property p_two_level;
        s_grp_rise ##1 !mask1_q[1] |=> host_irq_out;
    endproperty
    a_two_level: assert property (p_two_level)
        else $error("group edge did not raise interrupt");

    // Charger bits all masked at second level never reach the summary
    property p_masked_group;
        (stat_q[1] & ~mask2_q[1]) == 8'h00 && !sum_q[2] |=> !sum_q[2];
    endproperty
    a_masked_group: assert property (p_masked_group)
        else $error("masked group set its summary bit");

    property p_reserved;
        (stat_q[0] & ~pmic_irq_pkg::GRP_VALID[0]) == 8'h00 &&
        (mask2_q[4] & ~pmic_irq_pkg::GRP_VALID[4]) == 8'h00 && !sum_q[7];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

endmodule : pmic_irq_top

`default_nettype wire

// ==== hdl/reg_access_if.sv ====
// Register strobes between the serial port and the register file.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none

interface reg_access_if;
    logic       rd_stb;
    logic       wr_stb;
    logic [9:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport port (output rd_stb, output wr_stb, output addr,
                  output wdata, input rdata);
    modport regs (input rd_stb, input wr_stb, input addr,
                  input wdata, output rdata);
endinterface : reg_access_if

`default_nettype wire

// ==== testbench/host_model.sv ====
// Host side of the serial register port: frames, bursts and aborts.
// Assumes the port samples on falling edges and drives on rising edges.
`timescale 1ns/10ps
`default_nettype none

module host_model (
    // Host pins
    output var  logic host_port_clock,
    output var  logic host_port_select_n,
    output var  logic host_port_mosi,
    input  wire logic host_port_miso,
    input  wire logic host_port_miso_oe
);
    logic        line_q = 1'b0;
    logic [7:0]  rd_q [8];
    logic [15:0] head_q;
    logic [9:0]  wr_a [9];
    logic [7:0]  wr_d [9];
    wire         miso_line;

    // Released wire shows the inverse of the last driven bit
    assign miso_line = host_port_miso_oe ? host_port_miso : ~line_q;
    always @* begin
        if (host_port_miso_oe) begin
            line_q = host_port_miso;
        end
    end

    initial begin
        host_port_clock    = 1'b0;
        host_port_select_n = 1'b1;
        host_port_mosi     = 1'b0;
    end

    // Clock idles low, select held low for the whole burst
    task automatic sel(input logic on);
        if (on) begin
            #7 host_port_select_n = 1'b0;
            #400;
        end else begin
            #200 host_port_select_n = 1'b1;
            #600;
        end
    endtask : sel

    // Data changes on rising edge; latched late in the low phase to
    // allow for the synchronizer lag of the port
    task automatic shift(input logic [23:0] tx, input int n,
                         output logic [23:0] rx);
        rx = 24'h000000;
        for (int i = 0; i < n; i++) begin
            host_port_clock = 1'b1;
            host_port_mosi  = tx[23-i];
            #200 host_port_clock = 1'b0;
            #190 rx[23-i] = miso_line;
            #10;
        end
    endtask : shift

    // Junk after the address tests that reads ignore it
    task automatic read_burst(input logic [9:0] a, input int n);
        logic [23:0] rx;
        sel(1'b1);
        shift({1'b0, a, 5'h1F, 8'hA5}, 24, rx);
        head_q   = rx[23:8];
        rd_q[0]  = rx[7:0];
        for (int k = 1; k < n; k++) begin
            shift(24'h5A0000, 8, rx);
            rd_q[k] = rx[23:16];
        end
        sel(1'b0);
    endtask : read_burst

    // Spare bits sent as zero; packet count set by caller
    task automatic write_burst(input int n);
        logic [23:0] rx;
        sel(1'b1);
        for (int k = 0; k < n; k++) begin
            shift({1'b1, wr_a[k], 5'h00, wr_d[k]}, 24, rx);
        end
        sel(1'b0);
    endtask : write_burst

    task automatic write_cut(input logic [9:0] a, input logic [7:0] d,
                             input int n);
        logic [23:0] rx;
        sel(1'b1);
        shift({1'b1, a, 5'h00, d}, n, rx);
        sel(1'b0);
    endtask : write_cut
endmodule : host_model

`default_nettype wire

// ==== testbench/pmic_irq_and_host_serial_port_bench.sv ====
// Self-checking bench for the interrupt controller and its serial port.
// Assumes host_model as the far side; events driven on falling edges.
`timescale 1ns/10ps
`default_nettype none

module pmic_irq_and_host_serial_port_bench;
    logic       clk_sys   = 1'b0;
    logic       sys_rst   = 1'b1;
    logic       power_key = 1'b0;
    logic [7:0] ev [6]    = '{default: 8'h00};
    logic [7:0] sum_e;
    int         failures    = 0;
    int         checks_done = 0;
    wire        host_port_clock;
    wire        host_port_select_n;
    wire        host_port_mosi;
    wire        host_port_miso;
    wire        host_port_miso_oe;
    wire        host_irq_out;
    // Nine packets, unused bits zero; the ninth must be dropped
    localparam logic [17:0] PKT [9] = '{{10'h005, 8'h00}, {10'h060, 8'h07},
        {10'h0D1, 8'h02}, {10'h031, 8'h00}, {10'h198, 8'h00},
        {10'h05F, 8'h07}, {10'h0D1, 8'h00}, {10'h060, 8'h05},
        {10'h005, 8'h7F}};
    localparam logic [7:0]  GBIT [6] = '{8'h02, 8'h10, 8'h10, 8'h01,
                                         8'h01, 8'h01};

    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    pmic_irq_top dut_u (
        .clk_sys                (clk_sys),
        .sys_rst                (sys_rst),
        .host_port_clock        (host_port_clock),
        .host_port_select_n     (host_port_select_n),
        .host_port_mosi         (host_port_mosi),
        .host_port_miso         (host_port_miso),
        .host_port_miso_oe      (host_port_miso_oe),
        .host_irq_out           (host_irq_out),
        .power_key_event        (power_key),
        .converter_events       (ev[0]),
        .charger_events         (ev[1]),
        .clock_alarm_events     (ev[2]),
        .general_pin_events     (ev[3]),
        .regulator_fault_events (ev[4]),
        .audio_detect_events    (ev[5])
    );

    host_model host_u (
        .host_port_clock    (host_port_clock),
        .host_port_select_n (host_port_select_n),
        .host_port_mosi     (host_port_mosi),
        .host_port_miso     (host_port_miso),
        .host_port_miso_oe  (host_port_miso_oe)
    );

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic rd(input logic [9:0] a, input int n,
                      input logic [7:0] e0, input logic [7:0] e1);
        host_u.read_burst(a, n);
        check("read header", 16'h0000, host_u.head_q);
        check("read data", {8'h00, e0}, {8'h00, host_u.rd_q[0]});
        if (n > 1) begin
            check("next data", {8'h00, e1}, {8'h00, host_u.rd_q[1]});
        end
        check("miso drive", 16'h0000, {15'h0, host_port_miso_oe});
    endtask : rd

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_u.wr_a[0] = a;
        host_u.wr_d[0] = d;
        host_u.write_burst(1);
    endtask : wr

    // Sampled at a falling edge, away from the edge that updates it
    task automatic irq_is(input logic e);
        @(negedge clk_sys);
        check("irq", {15'h0, e}, {15'h0, host_irq_out});
    endtask : irq_is

    task automatic pulse(input int g, input logic [7:0] b);
        @(negedge clk_sys) ev[g] = b;
        @(negedge clk_sys) ev[g] = 8'h00;
        repeat (6) @(negedge clk_sys);
    endtask : pulse

    task report_and_stop;
        $display("Checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        #3000000;
        failures++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        // Reset values, first five as pairs read with address increment, last three singly
        rd(10'h004, 2, 8'h00, 8'hFA);
        rd(10'h030, 2, 8'h00, 8'h03);
        rd(10'h05F, 2, 8'h00, 8'h00);
        rd(10'h0D0, 2, 8'h00, 8'h00);
        rd(10'h197, 2, 8'h00, 8'h0F);
        rd(10'h01C, 1, 8'h00, 8'h00);
        rd(10'h0E8, 1, 8'h00, 8'h00);
        rd(10'h3FF, 1, 8'h00, 8'h00);
        // Frame cut short by deselect leaves no trace
        host_u.write_cut(10'h005, 8'h00, 20);
        rd(10'h005, 1, 8'hFA, 8'h00);
        for (int k = 0; k < 9; k++) begin
            host_u.wr_a[k] = PKT[k][17:8];
            host_u.wr_d[k] = PKT[k][7:0];
        end
        host_u.write_burst(9);
        rd(10'h005, 1, 8'h00, 8'h00);
        rd(10'h060, 1, 8'h05, 8'h00);
        rd(10'h0D1, 1, 8'h00, 8'h00);
        rd(10'h031, 1, 8'h00, 8'h00);
        rd(10'h198, 1, 8'h00, 8'h00);
        rd(10'h05F, 1, 8'h00, 8'h00);
        irq_is(1'b0);
        // Each group in turn, serviced summary first
        for (int g = 0; g < 6; g++) begin
            pulse(g, GBIT[g]);
            irq_is(1'b1);
            sum_e = 8'(8'h01 << (g + 1));
            rd(pmic_irq_pkg::ADDR_SUMMARY, 1, sum_e, 8'h00);
            irq_is(1'b0);
            rd(pmic_irq_pkg::GRP_STAT_ADDR[g], 1, GBIT[g], 8'h00);
            rd(pmic_irq_pkg::GRP_STAT_ADDR[g], 1, 8'h00, 8'h00);
        end
        // First level mask gates only the output
        wr(10'h005, 8'h04);
        pulse(1, 8'h20);
        irq_is(1'b0);
        wr(10'h005, 8'h00);
        irq_is(1'b1);
        rd(10'h004, 1, 8'h04, 8'h00);
        rd(10'h0D0, 1, 8'h20, 8'h00);
        irq_is(1'b0);
        // Second level mask keeps the summary bit clear
        wr(10'h0D1, 8'h08);
        pulse(1, 8'h08);
        irq_is(1'b0);
        rd(10'h0D0, 1, 8'h08, 8'h00);
        rd(10'h004, 1, 8'h00, 8'h00);
        wr(10'h0D1, 8'h00);
        // Event held through the clear keeps the line up
        @(negedge clk_sys) power_key = 1'b1;
        repeat (4) @(negedge clk_sys);
        rd(10'h004, 1, 8'h01, 8'h00);
        irq_is(1'b1);
        @(negedge clk_sys) power_key = 1'b0;
        rd(10'h004, 1, 8'h01, 8'h00);
        irq_is(1'b0);
        report_and_stop;
    end
endmodule : pmic_irq_and_host_serial_port_bench

`default_nettype wire
